// *** hdl/ppc_gear.sv ***
// electronic gear: numerator over denominator with carried remainder
`timescale 1ns/1ps
module ppc_gear import ppc_pkg::*; #(
    parameter int NW = 16,
    parameter int AW = 40
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ratio
    input wire logic [NW-1:0] num,
    input wire logic [NW-1:0] den,
    // input counts
    input wire logic in_step,
    input wire logic in_dir,
    // motor counts
    output logic out_step,
    output logic out_dir
);
    logic signed [AW-1:0] acc_r, acc_nxt, n_s, d_s;
    logic step_c, dir_c;

    always_comb begin
        n_s = $signed({{(AW-NW){1'b0}}, num});
        // a zero denominator would emit every cycle; treat it as one
        d_s = (den == '0) ? AW'(1) : $signed({{(AW-NW){1'b0}}, den});
        step_c = 1'b0;
        dir_c = 1'b0;
        acc_nxt = acc_r;
        // one motor count a cycle; the remainder stays in the sum
        if (acc_r >= d_s) begin
            step_c = 1'b1;
            dir_c = 1'b1;
            acc_nxt = acc_r - d_s;
        end else if (acc_r <= -d_s) begin
            step_c = 1'b1;
            acc_nxt = acc_r + d_s;
        end
        if (in_step) begin
            acc_nxt = in_dir ? acc_nxt + n_s : acc_nxt - n_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_r <= '0;
            out_step <= 1'b0;
            out_dir <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            out_step <= step_c;
            out_dir <= dir_c;
        end
    end

    a_gear_unity: assert property (@(posedge clk) disable iff (!rst_n)
        (num == 16'h1 && den == 16'h1 && acc_r == '0 && in_step) |=> ##1 (out_step && out_dir == $past(in_dir, 2)))
        else $error("unity gear did not pass the count");
    a_gear_rem: assert property (@(posedge clk) disable iff (!rst_n)
        (out_step && out_dir) |-> $past(acc_r) >= $past(d_s))
        else $error("forward count without remainder");
endmodule : ppc_gear

// *** hdl/ppc_pulse_decode.sv ***
// decoder of the incoming command pulse stream
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_pulse_decode import ppc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // setting and pins
    input wire logic [11:0] ptype,
    input wire logic pulse_a,
    input wire logic pulse_b,
    // decoded count
    output logic step,
    output logic dir
);
    logic a_r, b_r, step_c, dir_c;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            a_r <= 1'b0;
            b_r <= 1'b0;
        end else begin
            a_r <= pulse_a;
            b_r <= pulse_b;
        end
    end

    always_comb begin
        step_c = 1'b0;
        dir_c = 1'b0;
        case (ptype)
            `PPC_PT_QUAD: begin
                // every single-phase edge counts; both at once is illegal
                if ((pulse_a ^ a_r) ^ (pulse_b ^ b_r)) begin
                    step_c = 1'b1;
                    dir_c = pulse_a ^ b_r;
                end
            end
            `PPC_PT_CWCCW: begin
                if ((pulse_a & !a_r) ^ (pulse_b & !b_r)) begin
                    step_c = 1'b1;
                    dir_c = pulse_a & !a_r;
                end
            end
            `PPC_PT_PDIR: begin
                // direction level is taken as settled at the pulse edge
                step_c = pulse_a & !a_r;
                dir_c = pulse_b;
            end
            default: begin
                step_c = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step <= 1'b0;
            dir <= 1'b0;
        end else begin
            step <= step_c;
            dir <= dir_c;
        end
    end

    a_quad_edge: assert property (@(posedge clk) disable iff (!rst_n)
        (ptype == `PPC_PT_QUAD && (pulse_a != a_r) && (pulse_b == b_r))
        |=> step) else $error("quadrature edge not counted");
    a_pdir_dir: assert property (@(posedge clk) disable iff (!rst_n)
        (ptype == `PPC_PT_PDIR && pulse_a && !a_r) |=> (step && dir == $past(pulse_b)))
        else $error("pulse plus direction mis-decoded");
endmodule : ppc_pulse_decode

// *** hdl/ppc_top.sv ***
// pulse position command front end of a servo drive
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_top import ppc_pkg::*; #(
    parameter int NDI = 8,
    parameter int NW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    // command pulse pins
    input wire logic pulse_a,
    input wire logic pulse_b,
    // digital inputs and control power event
    input wire logic [NDI-1:0] digital_input,
    input wire logic ctrl_power_cycle,
    // jog keys
    input wire logic jog_mode,
    input wire logic jog_up,
    input wire logic jog_down,
    // motor command and status
    output logic motor_step,
    output logic motor_dir,
    output logic servo_on,
    output logic [4:0] alarm_code,
    output logic irq
);
    logic [11:0] ptype_r;
    logic [15:0] cmode_r, jog_spd_r;
    logic [NW-1:0] gnum_r, gden_r;
    logic force_r;
    logic [7:0] motor_r, node_r, fmt_r;
    logic [31:0] baud_r, pos_r, jog_acc_r;
    ppc_fcode_t [NDI-1:0] fpend_r, fact_r;
    logic [3:0] stat_r, mask_r, stat_set;
    logic alm_fs_r, alm_fl_r, alm_rl_r;
    logic en_lvl, arst_lvl, fs_lvl, fl_lvl, rl_lvl, servo_c, mode_ext, dir_inv;
    logic restore_hit, dec_step, dec_dir, g_step, g_dir, jog_tick, step_c, dir_c;
    ppc_jog_t jog_st_r, jog_nxt;

    function automatic ppc_fcode_t fn_default(input int idx);
        case (idx)
            0: fn_default = `PPC_DI1_DEF;
            4: fn_default = `PPC_DI5_DEF;
            5: fn_default = `PPC_DI6_DEF;
            6: fn_default = `PPC_DI7_DEF;
            7: fn_default = `PPC_DI8_DEF;
            default: fn_default = 12'h000;
        endcase
    endfunction : fn_default

    // asserted level of one function over all inputs
    function automatic logic fn_level(input ppc_fcode_t [NDI-1:0] codes,
                                      input logic [NDI-1:0] din, input logic [7:0] fid);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NDI; i++) begin
            if (fid != `PPC_FN_NONE && codes[i][7:0] == fid) begin
                hit = hit | ((codes[i][11:8] == `PPC_POL_NO) ? din[i] : !din[i]);
            end
        end
        return hit;
    endfunction : fn_level

    function automatic logic motor_ok(input logic [7:0] code);
        case (code)
            8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31: motor_ok = 1'b1;
            default: motor_ok = 1'b0;
        endcase
    endfunction : motor_ok

    function automatic logic wr(input logic [7:0] a);
        return reg_we && reg_addr == a;
    endfunction : wr

    assign restore_hit = wr(`PPC_A_RESTORE) && reg_wdata == `PPC_RESTORE_KEY;

    // parameters; restore shares the reset path
    always_ff @(posedge clk) begin
        if (!rst_n || restore_hit) begin
            ptype_r <= `PPC_PT_QUAD;
            cmode_r <= `PPC_CMODE_DEF;
            gnum_r <= NW'(`PPC_GEAR_DEF);
            gden_r <= NW'(`PPC_GEAR_DEF);
            jog_spd_r <= `PPC_JOG_DEF;
            motor_r <= `PPC_MOTOR_DEF;
            baud_r <= `PPC_BAUD_DEF;
            node_r <= `PPC_NODE_DEF;
            fmt_r <= `PPC_FMT_DEF;
        end else begin
            if (wr(`PPC_A_PTYPE)) ptype_r <= reg_wdata[11:0];
            if (wr(`PPC_A_CMODE)) cmode_r <= reg_wdata[15:0];
            if (wr(`PPC_A_GNUM)) gnum_r <= reg_wdata[NW-1:0];
            if (wr(`PPC_A_GDEN)) gden_r <= reg_wdata[NW-1:0];
            if (wr(`PPC_A_JOG)) jog_spd_r <= reg_wdata[15:0];
            // unknown motor codes are dropped, the old code stays
            if (wr(`PPC_A_MOTOR) && motor_ok(reg_wdata[7:0])) begin
                motor_r <= reg_wdata[7:0];
            end
            if (wr(`PPC_A_BAUD)) baud_r <= reg_wdata;
            if (wr(`PPC_A_NODE)) node_r <= reg_wdata[7:0];
            if (wr(`PPC_A_FMT)) fmt_r <= reg_wdata[7:0];
        end
    end

    // force enable lives until control power drops, a restore is written or another value is written to it
    always_ff @(posedge clk) begin
        if (!rst_n || restore_hit || ctrl_power_cycle) begin
            force_r <= 1'b0;
        end else if (wr(`PPC_A_FORCE)) begin
            force_r <= reg_wdata == `PPC_FORCE_ON;
        end
    end

    // pending codes are what software writes; active codes steer the inputs
    always_ff @(posedge clk) begin
        for (int i = 0; i < NDI; i++) begin
            if (!rst_n) begin
                fpend_r[i] <= fn_default(i);
                fact_r[i] <= fn_default(i);
            end else begin
                if (restore_hit) begin
                    fpend_r[i] <= fn_default(i);
                end else if (wr(`PPC_A_FPEND + 8'(i))) begin
                    fpend_r[i] <= reg_wdata[11:0];
                end
                if (ctrl_power_cycle) fact_r[i] <= fpend_r[i];
            end
        end
    end

    always_comb begin
        en_lvl = fn_level(fact_r, digital_input, `PPC_FN_EN);
        arst_lvl = fn_level(fact_r, digital_input, `PPC_FN_ARST);
        fs_lvl = fn_level(fact_r, digital_input, `PPC_FN_FSTOP);
        fl_lvl = fn_level(fact_r, digital_input, `PPC_FN_FLIM);
        rl_lvl = fn_level(fact_r, digital_input, `PPC_FN_RLIM);
    end

    // alarms; an active limit re-raises in the same cycle a reset clears it
    always_ff @(posedge clk) begin
        if (!rst_n || ctrl_power_cycle) begin
            alm_fs_r <= 1'b0;
            alm_fl_r <= 1'b0;
            alm_rl_r <= 1'b0;
        end else begin
            alm_fs_r <= fs_lvl;
            if (fl_lvl && !force_r) alm_fl_r <= 1'b1;
            else if (arst_lvl) alm_fl_r <= 1'b0;
            if (rl_lvl && !force_r) alm_rl_r <= 1'b1;
            else if (arst_lvl) alm_rl_r <= 1'b0;
        end
    end

    always_comb begin
        servo_c = !alm_fs_r && (force_r || (en_lvl && !alm_fl_r && !alm_rl_r));
        mode_ext = cmode_r[3:0] == `PPC_MODE_PT;
        dir_inv = cmode_r[11:8] == `PPC_DIR_REV;
    end

    ppc_pulse_decode u_dec (
        .clk(clk),
        .rst_n(rst_n),
        .ptype(ptype_r),
        .pulse_a(pulse_a),
        .pulse_b(pulse_b),
        .step(dec_step),
        .dir(dec_dir)
    );

    // disabled pulses are dropped, not stored for later
    ppc_gear #(.NW(NW)) u_gear (
        .clk(clk),
        .rst_n(rst_n),
        .num(gnum_r),
        .den(gden_r),
        .in_step(dec_step && servo_c && mode_ext && jog_st_r == JOG_IDLE),
        .in_dir(dec_dir),
        .out_step(g_step),
        .out_dir(g_dir)
    );

    // jog state
    always_comb begin
        jog_nxt = JOG_IDLE;
        if (jog_mode && servo_c) begin
            if (jog_up && !jog_down) jog_nxt = JOG_FWD;
            else if (jog_down && !jog_up) jog_nxt = JOG_REV;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) jog_st_r <= JOG_IDLE;
        else jog_st_r <= jog_nxt;
    end

    // rpm added each cycle; a count falls due every clk*60/rev rpm-units
    always_ff @(posedge clk) begin
        if (!rst_n || jog_st_r == JOG_IDLE) begin
            jog_acc_r <= '0;
        end else if (jog_tick) begin
            jog_acc_r <= jog_acc_r + 32'(jog_spd_r) - `PPC_JOG_DIV;
        end else begin
            jog_acc_r <= jog_acc_r + 32'(jog_spd_r);
        end
    end

    always_comb begin
        jog_tick = jog_st_r != JOG_IDLE && jog_acc_r >= `PPC_JOG_DIV;
        step_c = (jog_st_r == JOG_IDLE) ? g_step : jog_tick;
        dir_c = ((jog_st_r == JOG_IDLE) ? g_dir : jog_st_r == JOG_FWD) ^ dir_inv;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            motor_step <= 1'b0;
            motor_dir <= 1'b0;
            pos_r <= '0;
        end else begin
            motor_step <= step_c && servo_c;
            motor_dir <= dir_c;
            if (step_c && servo_c) pos_r <= dir_c ? pos_r + 32'h1 : pos_r - 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            servo_on <= 1'b0;
            alarm_code <= 5'h00;
        end else begin
            servo_on <= servo_c;
            alarm_code <= alm_fs_r ? `PPC_ALM_FSTOP : alm_fl_r ? `PPC_ALM_FLIM :
                          alm_rl_r ? `PPC_ALM_RLIM : 5'h00;
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    always_comb begin
        stat_set[0] = fs_lvl && !alm_fs_r;
        stat_set[1] = fl_lvl && !force_r && !alm_fl_r;
        stat_set[2] = rl_lvl && !force_r && !alm_rl_r;
        stat_set[3] = wr(`PPC_A_MOTOR) && !motor_ok(reg_wdata[7:0]);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) stat_r <= 4'h0;
        else if (wr(`PPC_A_STAT)) stat_r <= (stat_r & ~reg_wdata[3:0]) | stat_set;
        else stat_r <= stat_r | stat_set;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) mask_r <= 4'h0;
        else if (wr(`PPC_A_MASK)) mask_r <= reg_wdata[3:0];
    end

    assign irq = |(stat_r & mask_r);

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_n || !reg_re) begin
            reg_rdata <= '0;
        end else if (reg_addr >= `PPC_A_FACT && reg_addr < `PPC_A_FACT + 8'(NDI)) begin
            reg_rdata <= 32'(fact_r[reg_addr - `PPC_A_FACT]);
        end else if (reg_addr >= `PPC_A_FPEND && reg_addr < `PPC_A_FPEND + 8'(NDI)) begin
            reg_rdata <= 32'(fpend_r[reg_addr - `PPC_A_FPEND]);
        end else begin
            case (reg_addr)
                `PPC_A_PTYPE: reg_rdata <= 32'(ptype_r);
                `PPC_A_CMODE: reg_rdata <= 32'(cmode_r);
                `PPC_A_GNUM: reg_rdata <= 32'(gnum_r);
                `PPC_A_GDEN: reg_rdata <= 32'(gden_r);
                `PPC_A_FORCE: reg_rdata <= 32'(force_r);
                `PPC_A_JOG: reg_rdata <= 32'(jog_spd_r);
                `PPC_A_MOTOR: reg_rdata <= 32'(motor_r);
                `PPC_A_BAUD: reg_rdata <= baud_r;
                `PPC_A_NODE: reg_rdata <= 32'(node_r);
                `PPC_A_FMT: reg_rdata <= 32'(fmt_r);
                `PPC_A_STAT: reg_rdata <= 32'(stat_r);
                `PPC_A_MASK: reg_rdata <= 32'(mask_r);
                `PPC_A_STATE: reg_rdata <= {24'h0, servo_c, jog_st_r, alm_rl_r,
                                            alm_fl_r, alm_fs_r, en_lvl, force_r};
                `PPC_A_POS: reg_rdata <= pos_r;
                default: reg_rdata <= '0;
            endcase
        end
    end

    a_no_motion_off: assert property (@(posedge clk) disable iff (!rst_n)
        !servo_c |=> !motor_step) else $error("motor moved while disabled");
    a_force_enable: assert property (@(posedge clk) disable iff (!rst_n)
        (force_r && !alm_fs_r) |-> servo_c) else $error("force enable ignored");
    a_power_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_power_cycle |=> !force_r) else $error("force enable survived power cycle");
    a_func_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_power_cycle |=> $stable(fact_r)) else $error("input codes changed early");
    a_restore_defs: assert property (@(posedge clk) disable iff (!rst_n)
        restore_hit |=> (gnum_r == NW'(`PPC_GEAR_DEF) && fpend_r[0] == `PPC_DI1_DEF))
        else $error("restore left a parameter");
    a_limit_alarm: assert property (@(posedge clk) disable iff (!rst_n)
        (fl_lvl && !force_r && !ctrl_power_cycle) |=> (alm_fl_r ##1 alarm_code != 5'h00))
        else $error("forward limit alarm missing");
    a_fstop_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (!fs_lvl && alm_fs_r) |=> !alm_fs_r) else $error("fault stop alarm stuck");
    a_motor_code: assert property (@(posedge clk) disable iff (!rst_n)
        (wr(`PPC_A_MOTOR) && !motor_ok(reg_wdata[7:0]) && !restore_hit) |=> $stable(motor_r))
        else $error("bad motor code accepted");
    a_jog_exit: assert property (@(posedge clk) disable iff (!rst_n)
        (!jog_mode ##1 !jog_mode) |-> (jog_st_r == JOG_IDLE) ##1
        (jog_st_r == JOG_IDLE && jog_acc_r == '0)) else $error("jog did not stop");
    a_setpoint_mode: assert property (@(posedge clk) disable iff (!rst_n)
        (!mode_ext && jog_st_r == JOG_IDLE) [*4] |-> !motor_step)
        else $error("pulses moved motor in setpoint mode");
endmodule : ppc_top

// *** shared/ppc_cfg.svh ***
// constants for the pulse position command front end
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
`define PPC_CLK_HZ 100000000
`define PPC_COUNTS_REV 10000
`define PPC_JOG_DIV (32'((64'd`PPC_CLK_HZ * 64'd60) / 64'd`PPC_COUNTS_REV))
`define PPC_PT_QUAD 12'h000
`define PPC_PT_CWCCW 12'h001
`define PPC_PT_PDIR 12'h002
`define PPC_MODE_PT 4'h0
`define PPC_DIR_REV 4'h1
`define PPC_CMODE_DEF 16'h0000
`define PPC_GEAR_DEF 16'h0001
`define PPC_RESTORE_KEY 32'h0000000a
`define PPC_FORCE_ON 32'h00000001
`define PPC_JOG_DEF 16'h0064
`define PPC_MOTOR_DEF 8'h10
`define PPC_BAUD_DEF 32'h00004b00
`define PPC_NODE_DEF 8'h01
`define PPC_FMT_DEF 8'h18
`define PPC_FN_NONE 8'h00
`define PPC_FN_EN 8'h01
`define PPC_FN_ARST 8'h02
`define PPC_FN_FSTOP 8'h21
`define PPC_FN_RLIM 8'h22
`define PPC_FN_FLIM 8'h23
`define PPC_POL_NO 4'h1
`define PPC_DI1_DEF 12'h101
`define PPC_DI5_DEF 12'h102
`define PPC_DI6_DEF 12'h022
`define PPC_DI7_DEF 12'h023
`define PPC_DI8_DEF 12'h121
`define PPC_ALM_FSTOP 5'h0d
`define PPC_ALM_FLIM 5'h0e
`define PPC_ALM_RLIM 5'h0f
`define PPC_A_PTYPE 8'h00
`define PPC_A_CMODE 8'h01
`define PPC_A_GNUM 8'h02
`define PPC_A_GDEN 8'h03
`define PPC_A_RESTORE 8'h04
`define PPC_A_FORCE 8'h05
`define PPC_A_JOG 8'h06
`define PPC_A_MOTOR 8'h07
`define PPC_A_BAUD 8'h08
`define PPC_A_NODE 8'h09
`define PPC_A_FMT 8'h0a
`define PPC_A_STAT 8'h0b
`define PPC_A_MASK 8'h0c
`define PPC_A_STATE 8'h0d
`define PPC_A_POS 8'h0e
`define PPC_A_FPEND 8'h10
`define PPC_A_FACT 8'h18
`endif

// *** shared/ppc_pkg.sv ***
// types shared by the pulse position command front end
package ppc_pkg;
    typedef logic [11:0] ppc_fcode_t;
    typedef enum logic [1:0] {JOG_IDLE, JOG_FWD, JOG_REV} ppc_jog_t;
endpackage : ppc_pkg

// *** verification/ppc_src_model.sv ***
// pulse source model standing on the command pins
`timescale 1ns/1ps
module ppc_src_model (
    // clock
    input wire logic clk,
    // pulse type in use
    input wire logic [11:0] ptype,
    // command pins
    output logic pulse_a,
    output logic pulse_b
);
    logic [1:0] q = 2'h0;
    initial begin
        pulse_a = 1'b0;
        pulse_b = 1'b0;
    end
    // each unit is one count; callers keep quadrature runs whole turns of q
    task automatic send(input logic fwd, input int n);
        repeat (n) begin
            @(posedge clk);
            case (ptype)
                12'h000: begin
                    q = fwd ? q + 2'h1 : q - 2'h1;
                    pulse_a <= q[1] ^ q[0];
                    pulse_b <= q[1];
                end
                12'h001: begin
                    pulse_a <= fwd;
                    pulse_b <= !fwd;
                    @(posedge clk);
                    pulse_a <= 1'b0;
                    pulse_b <= 1'b0;
                end
                default: begin
                    pulse_b <= fwd; // level settles a cycle before the edge
                    @(posedge clk);
                    pulse_a <= 1'b1;
                    @(posedge clk);
                    pulse_a <= 1'b0;
                end
            endcase
            @(posedge clk);
        end
    endtask : send
endmodule : ppc_src_model

// *** verification/testbench.sv ***
// self-checking bench of the pulse position command front end
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [31:0] reg_rdata;
    logic pulse_a, pulse_b, ctrl_power_cycle = 1'b0;
    logic [7:0] digital_input = 8'h00;
    logic jog_mode = 1'b0, jog_up = 1'b0, jog_down = 1'b0;
    logic motor_step, motor_dir, servo_on, irq;
    logic [4:0] alarm_code;
    logic [11:0] pt = 12'h000;
    int pos = 0, p0, err_total = 0, checks = 0;
    logic [7:0] da[7] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h09, 8'h18, 8'h1d};
    logic [31:0] dv[7] = '{32'h1, 32'h1, 32'h64, 32'h10, 32'h1, 32'h101, 32'h22};
    always #5 clk = ~clk;
    ppc_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pulse_a(pulse_a),
        .pulse_b(pulse_b), .digital_input(digital_input),
        .ctrl_power_cycle(ctrl_power_cycle), .jog_mode(jog_mode), .jog_up(jog_up),
        .jog_down(jog_down), .motor_step(motor_step), .motor_dir(motor_dir),
        .servo_on(servo_on), .alarm_code(alarm_code), .irq(irq));
    ppc_src_model i_src (.clk(clk), .ptype(pt), .pulse_a(pulse_a), .pulse_b(pulse_b));
    // signed motor position seen at the output pins
    always @(posedge clk) begin
        if (motor_step === 1'b1) begin
            pos <= pos + (motor_dir ? 1 : -1);
        end
    end
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // bounded wait on the servo state; an overrun ends the run
    task automatic wait_on(input logic exp);
        int n;
        n = 0;
        while (servo_on !== exp && n < 16) begin
            @(posedge clk);
            n++;
        end
        if (servo_on !== exp) begin
            err_total++;
            complete_run();
        end
        chk(servo_on, exp);
    endtask : wait_on
    task automatic power_cycle();
        @(posedge clk);
        ctrl_power_cycle <= 1'b1;
        @(posedge clk);
        ctrl_power_cycle <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : power_cycle
    task automatic move(input logic fwd, input int n, input int delta);
        p0 = pos;
        i_src.send(fwd, n);
        repeat (8) @(posedge clk);
        chk(pos - p0, delta);
    endtask : move
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(da[i], dv[i]);
        rd(8'h08, 32'h4b00);
        chk(alarm_code, 5'h0e);
        rd(8'h0b, 32'h6);
        wr(8'h0c, 32'h2);
        #1 chk(irq, 1'b1);
        digital_input <= 8'h70;
        repeat (3) @(posedge clk);
        digital_input <= 8'h60;
        repeat (3) @(posedge clk);
        chk(alarm_code, 5'h00);
        wr(8'h0b, 32'h6);
        #1 chk(irq, 1'b0);
        digital_input <= 8'h61;
        wait_on(1'b1);
        for (int m = 0; m < 3; m++) begin
            pt = 12'(m);
            wr(8'h00, 32'(m));
            move(1'b1, 4, 4);
            move(1'b0, 4, -4);
        end
        wr(8'h02, 32'h2);
        wr(8'h03, 32'h3);
        move(1'b1, 6, 4);
        move(1'b1, 1, 0);
        move(1'b1, 2, 2);
        wr(8'h02, 32'h1);
        wr(8'h03, 32'h1);
        wr(8'h01, 32'h100);
        move(1'b1, 3, -3);
        wr(8'h01, 32'h1);
        move(1'b1, 3, 0);
        wr(8'h01, 32'h0);
        digital_input <= 8'h00;
        wait_on(1'b0);
        move(1'b1, 3, 0);
        wr(8'h05, 32'h1);
        wait_on(1'b1);
        wr(8'h10, 32'h0);
        rd(8'h18, 32'h101);
        power_cycle();
        wait_on(1'b0);
        rd(8'h18, 32'h0);
        digital_input <= 8'he0;
        repeat (4) @(posedge clk);
        chk(alarm_code, 5'h0d);
        digital_input <= 8'h60;
        repeat (4) @(posedge clk);
        // limit alarms latched since the power cycle stay until alarm reset
        chk(alarm_code, 5'h0e);
        wr(8'h0b, 32'hf);
        wr(8'h07, 32'h13);
        rd(8'h07, 32'h10);
        rd(8'h0b, 32'h8);
        wr(8'h07, 32'h31);
        rd(8'h07, 32'h31);
        wr(8'h04, 32'ha);
        rd(8'h07, 32'h10);
        wr(8'h05, 32'h1);
        wait_on(1'b1);
        jog_mode <= 1'b1;
        jog_up <= 1'b1;
        p0 = pos;
        repeat (12500) @(posedge clk);
        jog_up <= 1'b0;
        repeat (7000) @(posedge clk);
        chk(pos - p0, 2);
        complete_run();
    end
endmodule : testbench
